/* File: inc/cmfd_pkg.sv */
// Constants and carrier types for the cell monitor fault diagnostics block.
package cmfd_pkg;

    localparam int          CELL_COUNT          = 12;
    localparam int          TEMP_COUNT          = 4;
    localparam int          WIRE_COUNT          = 13;
    localparam int          SAMPLE_W            = 14;
    localparam int          CHECKSUM_W          = 16;
    localparam logic [3:0]  CELL_LAST_INDEX     = 4'hB;
    localparam logic [3:0]  WIRE_LAST_INDEX     = 4'hC;
    localparam logic [3:0]  WIRE_ALWAYS_TESTED  = 4'h2;

    // Cell code 14'h1FFF stands for 5 V; codes above it read as full scale.
    localparam logic [13:0] CELL_FULL_SCALE     = 14'h1FFF;
    // Temperature code 14'h3FFF stands for 2.5 V.
    localparam logic [13:0] TEMP_FULL_SCALE     = 14'h3FFF;

    // Filter setting after reset: 2**3 = eight consecutive samples.
    localparam logic [2:0]  FILTER_COUNT_RESET  = 3'b011;

    // Settling time of one open-wire probe before its comparator is read.
    localparam int          CLK_PERIOD_NS       = 8;
    localparam int          WIRE_SETTLE_NS      = 1000;
    localparam int          WIRE_SETTLE_CYCLES  = (WIRE_SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    typedef struct packed {
        logic osc;
        logic checksum;
        logic over_temp;
        logic open_wire;
        logic open_conn;
        logic uv;
        logic ov;
    } cmfd_status_type;

    typedef struct packed {
        logic [13:0] ov_limit;
        logic [13:0] uv_limit;
        logic [13:0] temp_limit;
        logic [11:0] cell_setup;
        logic        open_wire_current_select;
        logic [3:0]  temp_input_test_select;
    } cmfd_cfg_type;

    typedef struct packed {
        logic        valid;
        logic [3:0]  index;
        logic [13:0] value;
        logic        open_conn;
    } cmfd_cell_sample_type;

    typedef struct packed {
        logic        valid;
        logic [1:0]  index;
        logic [13:0] value;
    } cmfd_temp_sample_type;

    typedef struct packed {
        logic [11:0]     ov;
        logic [11:0]     uv;
        logic [12:0]     open_wire;
        logic [3:0]      over_temp;
        cmfd_status_type status;
    } cmfd_clear_type;

    typedef enum logic [1:0] {
        WIRE_IDLE  = 2'b01,
        WIRE_PROBE = 2'b10
    } cmfd_wire_state_type;

endpackage

/* File: logic/cmfd_core.sv */
// Fault detection, filtering, flags, checksum and fault report of the cell monitor.
//
// Notes on behaviour
// - Monitored functions set summary fault status bits.
// - Oscillator fault sets flag, then enters sleep.
// - Sleeping device ignores normal commands.
// - Cell limits use 14'h1FFF as 5V.
// - Filter sample setting resets to 3'b011.
// - Unconnected cells skip overvoltage and undervoltage.
// - Overvoltage flagged after programmed consecutive samples.
// - Undervoltage flagged after programmed consecutive samples.
// - Open top/ground flagged after consecutive samples.
// - Report status unprompted only if previously zero.
// - Changing filter setting clears all counts.
// - Passing sample resets that cell's count.
// - Current select: one gives 1mA, zero 150uA.
// - Open-wire skips the upper input of each unconnected cell; inputs 0 and 1 always tested.
// - Temperature limit uses 14'h3FFF as 2.5V.
// - Per-input select enables over-temperature checking.
// - Over-temperature flagged on first low sample.
// - Calculate command stores configuration checksum.
// - Check command recomputes, flags mismatch.
// - Fault output low while any status bit.
// - Summary bit holds while specific bits set.
`timescale 1ns/10ps

module cmfd_core
    import cmfd_pkg::*;
#(
    parameter int CFG_WORDS = 32,
    parameter int CNT_W     = 8
) (
    input  wire logic                                clk_sys,
    input  wire logic                                sys_rst,
    input  wire cmfd_cfg_type                        cfg,
    input  wire logic [CFG_WORDS-1:0][SAMPLE_W-1:0]  page2_image,
    input  wire logic                                filter_count_write,
    input  wire logic [2:0]                          filter_count_data,
    input  wire cmfd_cell_sample_type                cell_sample,
    input  wire cmfd_temp_sample_type                temp_sample,
    input  wire logic                                osc_fault_detect,
    input  wire logic                                wire_probe_open,
    input  wire logic                                cmd_scan_wires,
    input  wire logic                                cmd_calc_checksum,
    input  wire logic                                cmd_check_checksum,
    input  wire logic                                cmd_wakeup,
    input  wire logic                                fault_clear_valid,
    input  wire cmfd_clear_type                      fault_clear,
    input  wire logic                                link_busy,
    output logic [2:0]                               fault_filter_sample_count,
    output logic [CELL_COUNT-1:0]                    ov_fault,
    output logic [CELL_COUNT-1:0]                    uv_fault,
    output logic [WIRE_COUNT-1:0]                    open_wire_fault,
    output logic [TEMP_COUNT-1:0]                    over_temp_fault,
    output cmfd_status_type                          fault_status,
    output logic                                     fault_n,
    output logic                                     sleep_state,
    output logic                                     scan_wires_busy,
    output logic                                     wire_probe_active,
    output logic [3:0]                               wire_probe_index,
    output logic                                     scan_current_1ma,
    output logic                                     scan_current_150ua,
    output logic [CHECKSUM_W-1:0]                    checksum_stored,
    output logic                                     fault_report_valid,
    output cmfd_status_type                          fault_report_data
);

    if (CNT_W < 8 || CFG_WORDS < 1) begin : g_param_check
        $error("cmfd_core: CNT_W must reach 128 and CFG_WORDS must be positive.");
    end

    // Count step of one consecutive-sample filter: hit flag above the new count.
    function automatic logic [CNT_W:0] filt_step(input logic [CNT_W-1:0] cnt,
                                                 input logic             cond,
                                                 input logic [CNT_W-1:0] thr);
        logic [CNT_W-1:0] inc;
        inc = (cnt >= thr) ? thr : cnt + 1'b1;
        filt_step = cond ? {inc >= thr, inc} : '0;
    endfunction

    // Rotate and fold checksum over the configuration image.
    function automatic logic [CHECKSUM_W-1:0] page2_sum(input logic [CFG_WORDS-1:0][SAMPLE_W-1:0] img);
        logic [CHECKSUM_W-1:0] acc;
        acc = '0;
        for (int i = 0; i < CFG_WORDS; i++) begin
            acc = {acc[CHECKSUM_W-2:0], acc[CHECKSUM_W-1]} ^ {2'h0, img[i]};
        end
        page2_sum = acc;
    endfunction

    function automatic logic wire_enabled(input logic [3:0] idx, input logic [11:0] setup);
        wire_enabled = (idx < WIRE_ALWAYS_TESTED) || !setup[idx - 4'h1];
    endfunction

    logic [CNT_W-1:0]       ov_cnt [CELL_COUNT];
    logic [CNT_W-1:0]       uv_cnt [CELL_COUNT];
    logic [CNT_W-1:0]       oc_cnt [CELL_COUNT];
    logic [CNT_W-1:0]       thr;
    logic                   cmd_ok;
    logic                   filter_changed;
    logic                   s_ok;
    logic [3:0]             s_idx;
    logic                   connected;
    logic [13:0]            cell_value;
    logic                   ov_cond;
    logic                   uv_cond;
    logic [CNT_W:0]         ov_step;
    logic [CNT_W:0]         uv_step;
    logic [CNT_W:0]         oc_step;
    logic [CELL_COUNT-1:0]  ov_set;
    logic [CELL_COUNT-1:0]  uv_set;
    logic                   oc_set;
    logic [TEMP_COUNT-1:0]  ot_set;
    logic [WIRE_COUNT-1:0]  ow_set;
    logic [CHECKSUM_W-1:0]  checksum_now;
    logic                   mismatch_set;
    logic                   osc_seen;
    logic                   report_pending;
    logic [$clog2(WIRE_SETTLE_CYCLES+1)-1:0] settle_cnt;
    cmfd_wire_state_type    wire_state;
    cmfd_clear_type         clr;
    cmfd_status_type        set_bits;
    cmfd_status_type        next_status;
    logic [CELL_COUNT-1:0]  next_ov_fault;
    logic [CELL_COUNT-1:0]  next_uv_fault;
    logic [WIRE_COUNT-1:0]  next_open_wire_fault;
    logic [TEMP_COUNT-1:0]  next_over_temp_fault;

    assign cmd_ok         = !sleep_state;
    assign filter_changed = filter_count_write && (filter_count_data != fault_filter_sample_count);
    assign thr            = CNT_W'(1) << fault_filter_sample_count;
    assign s_ok           = cell_sample.valid && !sleep_state && (cell_sample.index <= CELL_LAST_INDEX);
    assign s_idx          = cell_sample.index;
    assign connected      = !cfg.cell_setup[s_idx];
    assign cell_value     = (cell_sample.value > CELL_FULL_SCALE) ? CELL_FULL_SCALE : cell_sample.value;
    assign ov_cond        = cell_value > cfg.ov_limit;
    assign uv_cond        = cell_value < cfg.uv_limit;
    assign ov_step        = filt_step(ov_cnt[s_idx], ov_cond, thr);
    assign uv_step        = filt_step(uv_cnt[s_idx], uv_cond, thr);
    assign oc_step        = filt_step(oc_cnt[s_idx], cell_sample.open_conn, thr);
    assign ov_set         = (s_ok && connected && ov_step[CNT_W]) ? 12'h001 << s_idx : '0;
    assign uv_set         = (s_ok && connected && uv_step[CNT_W]) ? 12'h001 << s_idx : '0;
    assign oc_set         = s_ok && oc_step[CNT_W];
    assign checksum_now   = page2_sum(page2_image);
    assign mismatch_set   = cmd_ok && cmd_check_checksum && (checksum_now != checksum_stored);
    assign clr            = fault_clear_valid ? fault_clear : '0;

    // Over-temperature needs no filter: a single low sample on a tested input counts.
    always_comb begin
        ot_set = '0;
        if (temp_sample.valid && !sleep_state && cfg.temp_input_test_select[temp_sample.index] &&
            (temp_sample.value < (cfg.temp_limit & TEMP_FULL_SCALE))) begin
            ot_set[temp_sample.index] = 1'b1;
        end
    end

    always_comb begin
        ow_set = '0;
        if (wire_state == WIRE_PROBE && wire_enabled(wire_probe_index, cfg.cell_setup) &&
            settle_cnt == '0 && wire_probe_open) begin
            ow_set[wire_probe_index] = 1'b1;
        end
    end

    // Hardware sets win over a host clear arriving in the same cycle.
    assign next_ov_fault        = (ov_fault & ~clr.ov) | ov_set;
    assign next_uv_fault        = (uv_fault & ~clr.uv) | uv_set;
    assign next_open_wire_fault = (open_wire_fault & ~clr.open_wire) | ow_set;
    assign next_over_temp_fault = (over_temp_fault & ~clr.over_temp) | ot_set;

    always_comb begin
        set_bits           = '0;
        set_bits.ov        = |ov_set;
        set_bits.uv        = |uv_set;
        set_bits.open_conn = oc_set;
        set_bits.open_wire = |ow_set;
        set_bits.over_temp = |ot_set;
        set_bits.checksum  = mismatch_set;
        set_bits.osc       = osc_fault_detect;
        next_status        = (fault_status & ~clr.status) | set_bits;
        // A summary bit stays while its specific register still holds bits.
        next_status.ov        = next_status.ov || (next_ov_fault != '0);
        next_status.uv        = next_status.uv || (next_uv_fault != '0);
        next_status.open_wire = next_status.open_wire || (next_open_wire_fault != '0);
        next_status.over_temp = next_status.over_temp || (next_over_temp_fault != '0);
    end

    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            fault_filter_sample_count <= FILTER_COUNT_RESET;
        end else if (filter_count_write && cmd_ok) begin
            fault_filter_sample_count <= filter_count_data;
        end
    end

    // Consecutive-sample counters for overvoltage, undervoltage and open connection.
    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            for (int i = 0; i < CELL_COUNT; i++) begin
                ov_cnt[i] <= '0;
                uv_cnt[i] <= '0;
                oc_cnt[i] <= '0;
            end
        end else if (filter_changed && cmd_ok) begin
            for (int i = 0; i < CELL_COUNT; i++) begin
                ov_cnt[i] <= '0;
                uv_cnt[i] <= '0;
                oc_cnt[i] <= '0;
            end
        end else if (s_ok) begin
            ov_cnt[s_idx] <= connected ? ov_step[CNT_W-1:0] : '0;
            uv_cnt[s_idx] <= connected ? uv_step[CNT_W-1:0] : '0;
            oc_cnt[s_idx] <= oc_step[CNT_W-1:0];
        end
    end

    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            ov_fault        <= '0;
            uv_fault        <= '0;
            open_wire_fault <= '0;
            over_temp_fault <= '0;
            fault_status    <= '0;
            fault_n         <= 1'b1;
        end else begin
            ov_fault        <= next_ov_fault;
            uv_fault        <= next_uv_fault;
            open_wire_fault <= next_open_wire_fault;
            over_temp_fault <= next_over_temp_fault;
            fault_status    <= next_status;
            fault_n         <= (next_status == '0);
        end
    end

    // The flag is set in the detecting cycle, sleep follows one cycle later.
    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            osc_seen    <= 1'b0;
            sleep_state <= 1'b0;
        end else begin
            osc_seen <= osc_fault_detect;
            if (osc_seen) begin
                sleep_state <= 1'b1;
            end else if (cmd_wakeup) begin
                sleep_state <= 1'b0;
            end
        end
    end

    // Unprompted report waits for a quiet link and fires only from a clean status.
    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            report_pending     <= 1'b0;
            fault_report_valid <= 1'b0;
            fault_report_data  <= '0;
        end else begin
            fault_report_valid <= 1'b0;
            if (fault_status == '0 && next_status != '0) begin
                report_pending <= 1'b1;
            end else if (report_pending && !link_busy) begin
                report_pending     <= 1'b0;
                fault_report_valid <= 1'b1;
                fault_report_data  <= fault_status;
            end
        end
    end

    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            checksum_stored <= '0;
        end else if (cmd_ok && cmd_calc_checksum) begin
            checksum_stored <= checksum_now;
        end
    end

    // Open-wire scan walks inputs 0 to 12, probing each enabled one for a settle time.
    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            wire_state       <= WIRE_IDLE;
            wire_probe_index <= '0;
            settle_cnt       <= '0;
        end else begin
            unique case (wire_state)
                WIRE_IDLE: begin
                    if (cmd_ok && cmd_scan_wires) begin
                        wire_state       <= WIRE_PROBE;
                        wire_probe_index <= '0;
                        settle_cnt       <= ($bits(settle_cnt))'(WIRE_SETTLE_CYCLES - 1);
                    end
                end
                WIRE_PROBE: begin
                    if (wire_enabled(wire_probe_index, cfg.cell_setup) && settle_cnt != '0) begin
                        settle_cnt <= settle_cnt - 1'b1;
                    end else if (wire_probe_index == WIRE_LAST_INDEX) begin
                        wire_state <= WIRE_IDLE;
                    end else begin
                        wire_probe_index <= wire_probe_index + 4'h1;
                        settle_cnt       <= ($bits(settle_cnt))'(WIRE_SETTLE_CYCLES - 1);
                    end
                end
                default: wire_state <= WIRE_IDLE;
            endcase
        end
    end

    assign scan_wires_busy    = (wire_state == WIRE_PROBE);
    assign wire_probe_active  = scan_wires_busy && wire_enabled(wire_probe_index, cfg.cell_setup);
    assign scan_current_1ma   = wire_probe_active && cfg.open_wire_current_select;
    assign scan_current_150ua = wire_probe_active && !cfg.open_wire_current_select;
    logic [3:0] last_idx;
    logic       all_cnt_zero;
    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            last_idx <= '0;
        end else begin
            last_idx <= s_idx;
        end
    end
    always_comb begin
        all_cnt_zero = 1'b1;
        for (int i = 0; i < CELL_COUNT; i++) begin
            if (ov_cnt[i] != '0 || uv_cnt[i] != '0 || oc_cnt[i] != '0) begin
                all_cnt_zero = 1'b0;
            end
        end
    end
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (sys_rst);

    a_fault_pin_level: assert property (fault_n == (fault_status == '0))
        else $error("Fault output disagrees with status.");
    a_osc_then_sleep: assert property (osc_fault_detect && !sleep_state |=> fault_status.osc ##1 sleep_state)
        else $error("Oscillator fault did not flag then sleep.");
    a_sleep_ignores_cmd: assert property (sleep_state && !scan_wires_busy && cmd_scan_wires |=> !scan_wires_busy)
        else $error("Sleeping device started a wire scan.");
    a_ov_needs_sample: assert property ($rose(|ov_fault) |-> $past(s_ok && ov_cond && connected))
        else $error("Overvoltage flag rose without a qualifying sample.");
    a_filter_clears: assert property (filter_changed && cmd_ok |=> all_cnt_zero)
        else $error("Filter change left counts behind.");
    a_pass_resets_cnt: assert property (s_ok && !uv_cond && !filter_changed |=> uv_cnt[last_idx] == '0)
        else $error("Passing sample did not reset the count.");
    a_flags_sticky: assert property ((($past(ov_fault) & ~ov_fault) != '0) |-> $past(fault_clear_valid))
        else $error("Overvoltage flag fell without a clear.");
    a_summary_holds: assert property (fault_status.ov && (ov_fault & ~clr.ov) != '0 |=> fault_status.ov)
        else $error("Summary overvoltage bit cleared too early.");
    a_report_once: assert property ($rose(fault_status != '0) && !link_busy |=> fault_report_valid)
        else $error("First fault produced no report.");
    a_unconn_skip: assert property (s_ok && !connected && !fault_clear_valid |=> ov_fault == $past(ov_fault))
        else $error("Unconnected cell raised overvoltage.");
    a_temp_first: assert property (ot_set != '0 |=> (over_temp_fault & $past(ot_set)) == $past(ot_set))
        else $error("Over-temperature not flagged on first sample.");
    a_checksum_flag: assert property (mismatch_set |=> fault_status.checksum)
        else $error("Checksum mismatch not flagged.");
    a_wire_current: assert property (scan_current_1ma |-> cfg.open_wire_current_select && wire_probe_active)
        else $error("Large scan current outside its selection.");

    c_ov_fault: cover property ($rose(|ov_fault));
    c_wire_scan: cover property ($fell(scan_wires_busy));
    c_report: cover property (fault_report_valid);
    c_sleep: cover property ($rose(sleep_state));
endmodule

/* File: testbench/cmfd_host.sv */
// Host model that clears fault registers in the order the device expects.
`timescale 1ns/10ps
module cmfd_host
    import cmfd_pkg::*;
(
    input  wire logic       clk_sys,
    input  wire logic [1:0] clear_mode,
    output cmfd_clear_type  fault_clear,
    output logic            fault_clear_valid
);
    logic [1:0] mode;
    initial begin
        fault_clear_valid = 1'b0;
        fault_clear = '0;
        forever begin
            @(posedge clk_sys);
            mode = clear_mode;
            if (mode[0]) begin
                fault_clear_valid <= 1'b1;
                fault_clear <= cmfd_clear_type'({41'h1FF_FFFF_FFFF, 7'h00});
                @(posedge clk_sys);
            end
            if (mode != 2'b00) begin
                fault_clear_valid <= 1'b1;
                fault_clear <= cmfd_clear_type'(48'h0000_0000_007F);
                @(posedge clk_sys);
                fault_clear_valid <= 1'b0;
                fault_clear <= ~fault_clear;
            end
        end
    end
endmodule

/* File: testbench/cell_monitor_fault_diagnostics_tb.sv */
// Self-checking bench for the cell monitor fault diagnostics block.
`timescale 1ns/10ps
`define CHK(n, e, g) begin check_count++; if ((g) !== (e)) begin fail_count++; $display("ERROR %s expected %0h seen %0h", n, e, g); end end
module cell_monitor_fault_diagnostics_tb
    import cmfd_pkg::*;
;
    logic                 clk_sys, sys_rst, wire_probe_open, fault_n, sleep_state, scan_wires_busy;
    logic                 wire_probe_active, scan_current_1ma, scan_current_150ua, fault_report_valid;
    logic                 fault_clear_valid;
    logic [6:0]           cmd;
    logic [1:0]           clear_mode;
    logic [2:0]           filter_count_data, fault_filter_sample_count;
    logic [3:0]           c, u, wire_probe_index, over_temp_fault;
    logic [11:0]          ov_fault, uv_fault;
    logic [12:0]          open_wire_fault, open_set, wen;
    logic [15:0]          checksum_stored, sum0;
    logic [31:0][13:0]    page2_image;
    int                   fail_count, check_count, cycles, rep_cnt, act_cnt, cur_bad, thr, k;
    cmfd_cfg_type         cfg;
    cmfd_cell_sample_type cell_sample;
    cmfd_temp_sample_type temp_sample;
    cmfd_clear_type       fault_clear;
    cmfd_status_type      fault_status, fault_report_data;

    cmfd_core i_cmfd_core (.clk_sys, .sys_rst, .cfg, .page2_image, .filter_count_write(cmd[5]), .filter_count_data,
        .cell_sample, .temp_sample, .osc_fault_detect(cmd[4]), .wire_probe_open, .cmd_scan_wires(cmd[3]),
        .cmd_calc_checksum(cmd[2]), .cmd_check_checksum(cmd[1]), .cmd_wakeup(cmd[0]), .fault_clear_valid,
        .fault_clear, .link_busy(cmd[6]), .fault_filter_sample_count, .ov_fault, .uv_fault, .open_wire_fault,
        .over_temp_fault, .fault_status, .fault_n, .sleep_state, .scan_wires_busy, .wire_probe_active,
        .wire_probe_index, .scan_current_1ma, .scan_current_150ua, .checksum_stored, .fault_report_valid,
        .fault_report_data);
    cmfd_host i_cmfd_host (.clk_sys, .clear_mode, .fault_clear, .fault_clear_valid);

    initial begin
        clk_sys = 1'b0;
        forever #4 clk_sys = ~clk_sys;
    end

    always @(posedge clk_sys) begin
        cycles <= cycles + 1;
        wire_probe_open <= open_set[wire_probe_index];
        if (fault_report_valid === 1'b1) rep_cnt <= rep_cnt + 1;
        if (wire_probe_active === 1'b1) act_cnt <= act_cnt + 1;
        if (wire_probe_active === 1'b1 && scan_current_1ma !== cfg.open_wire_current_select) cur_bad <= cur_bad + 1;
        if (wire_probe_active === 1'b1 && scan_current_150ua !== !cfg.open_wire_current_select) cur_bad <= cur_bad + 1;
        if (cycles == 12000) begin
            fail_count++;
            complete_run();
        end
    end

    function logic [12:0] wire_mask(input logic [11:0] setup);
        return {~setup[11:1], 2'b11};
    endfunction

    task tk(input int n);
        repeat (n) @(posedge clk_sys);
        #1;
    endtask

    task smp(input int n, input logic [3:0] i, input logic [13:0] v, input logic oc);
        repeat (n) begin
            @(posedge clk_sys);
            cell_sample <= '{1'b1, i, v, oc};
        end
        @(posedge clk_sys);
        cell_sample.valid <= 1'b0;
        tk(1);
    endtask

    task pls(input int b);
        @(posedge clk_sys);
        cmd[b] <= 1'b1;
        @(posedge clk_sys);
        cmd[b] <= 1'b0;
        tk(2);
    endtask

    task fw(input logic [2:0] v);
        @(posedge clk_sys);
        filter_count_data <= v;
        pls(5);
    endtask

    task clr(input logic [1:0] m);
        @(posedge clk_sys);
        clear_mode <= m;
        @(posedge clk_sys);
        clear_mode <= 2'b00;
        tk(5);
    endtask

    task complete_run();
        $display("Checks %0d, mismatches %0d", check_count, fail_count);
        if (fail_count == 0 && check_count > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    initial begin
        void'($urandom(32'h1C93D57D));
        {sys_rst, cmd, clear_mode, filter_count_data, cell_sample, temp_sample, open_set, wire_probe_open} = '1;
        {cmd, clear_mode, cell_sample, temp_sample, open_set, wire_probe_open} = '0;
        for (k = 0; k < 32; k++) page2_image[k] = 14'($urandom());
        c = 4'($urandom_range(11));
        u = (c == 4'hB) ? 4'h0 : c + 4'h1;
        cfg.ov_limit = 14'($urandom_range(14'h1F00, 14'h1000));
        cfg.uv_limit = 14'($urandom_range(14'h0800, 14'h0100));
        cfg.temp_limit = 14'($urandom_range(14'h3FFF, 14'h0100));
        cfg.cell_setup = 12'($urandom());
        cfg.cell_setup[c] = 1'b0;
        cfg.cell_setup[u] = 1'b1;
        cfg.open_wire_current_select = 1'($urandom());
        cfg.temp_input_test_select = 4'($urandom());
        repeat (16) @(posedge clk_sys);
        sys_rst <= 1'b0;
        tk(1);
        `CHK("filter count", 3'b011, fault_filter_sample_count)
        `CHK("fault pin", 1'b1, fault_n)
        thr = 1 << 3'b011;
        smp(thr - 1, c, CELL_FULL_SCALE, 1'b0);
        smp(1, c, 14'h0C00, 1'b0);
        smp(thr - 1, c, CELL_FULL_SCALE, 1'b0);
        `CHK("ov early", 1'b0, ov_fault[c])
        smp(1, c, CELL_FULL_SCALE, 1'b0);
        `CHK("ov summary", 1'b1, fault_status.ov)
        `CHK("fault pin", 1'b0, fault_n)
        smp(thr, u, CELL_FULL_SCALE, 1'b0);
        smp(1, c, 14'h0C00, 1'b0);
        `CHK("ov flags", 12'h001 << c, ov_fault)
        `CHK("reports", 1, rep_cnt)
        $display("Test overvoltage finished");
        fw(3'b001);
        smp(1, c, 14'h0040, 1'b0);
        fw(3'b010);
        fw(3'b001);
        smp(1, c, 14'h0040, 1'b0);
        `CHK("uv early", 1'b0, uv_fault[c])
        smp(1, c, 14'h0040, 1'b0);
        `CHK("uv flag", 1'b1, uv_fault[c])
        `CHK("reports", 1, rep_cnt)
        clr(2'b10);
        `CHK("summary held", 1'b1, fault_status.ov)
        clr(2'b01);
        `CHK("fault pin", 1'b1, fault_n)
        $display("Test filter and clear finished");
        smp(1, u, 14'h0C00, 1'b1);
        smp(1, u, 14'h0C00, 1'b0);
        smp(1, u, 14'h0C00, 1'b1);
        `CHK("open early", 1'b0, fault_status.open_conn)
        @(posedge clk_sys) cmd[6] <= 1'b1;
        smp(1, u, 14'h0C00, 1'b1);
        `CHK("open conn", 1'b1, fault_status.open_conn)
        tk(2);
        `CHK("report held", 1, rep_cnt)
        @(posedge clk_sys) cmd[6] <= 1'b0;
        tk(2);
        `CHK("reports", 2, rep_cnt)
        `CHK("report data", 7'h04, fault_report_data)
        clr(2'b01);
        for (k = 0; k < 4; k++) begin
            @(posedge clk_sys);
            temp_sample <= '{1'b1, 2'(k), cfg.temp_limit - 14'h0001};
        end
        @(posedge clk_sys);
        temp_sample.valid <= 1'b0;
        tk(2);
        `CHK("temp flags", cfg.temp_input_test_select, over_temp_fault)
        clr(2'b01);
        $display("Test open and temperature finished");
        @(posedge clk_sys);
        open_set <= 13'($urandom());
        k = act_cnt;
        pls(3);
        while (scan_wires_busy === 1'b1) @(posedge clk_sys);
        tk(2);
        wen = wire_mask(cfg.cell_setup);
        `CHK("wire flags", open_set & wen, open_wire_fault)
        `CHK("probe cycles", WIRE_SETTLE_CYCLES * $countones(wen), act_cnt - k)
        `CHK("scan current", 0, cur_bad)
        clr(2'b01);
        pls(2);
        sum0 = checksum_stored;
        pls(1);
        `CHK("checksum ok", 1'b0, fault_status.checksum)
        @(posedge clk_sys);
        page2_image[0][0] <= ~page2_image[0][0];
        pls(1);
        `CHK("checksum bad", 1'b1, fault_status.checksum)
        pls(2);
        `CHK("checksum moved", 1'b1, checksum_stored !== sum0)
        clr(2'b01);
        pls(4);
        `CHK("osc flag", 1'b1, fault_status.osc)
        `CHK("asleep", 1'b1, sleep_state)
        smp(thr, c, 14'h0040, 1'b0);
        `CHK("uv asleep", 12'h000, uv_fault)
        pls(3);
        `CHK("scan asleep", 1'b0, scan_wires_busy)
        pls(0);
        `CHK("awake", 1'b0, sleep_state)
        $display("Test wires, checksum and sleep finished");
        complete_run();
    end
endmodule
